// [far_alarm_unit.sv]
// far_alarm_unit: alarm aggregation, reset/exception response, stack limits,
// eeprom high-voltage flag, per-byte eeprom correction, rom parity reset
// assumes sensors and straps are asynchronous pins; cpu signals share clk
//
// Contract
// - sensor, fetch, cache faults force chip reset
// - eeprom light and other faults raise exception
// - reset aborts program, exception interrupts it
// - reset clears state, keeps readable cause
// - exception cause readable by software
// - inverse correction error raises exception
// - sensors on in every non-test mode
// - software cannot disable sensors
// - reset/exception mapping is hard-wired
// - three stack pointers, limit exception each
// - write high voltage posted, no event
// - eeprom byte single-bit errors corrected
// - rom parity failure forces chip reset
// - fault detection on pc, sp, psw, cache, crypto
// - test mode off after delivery
`timescale 1ns/1ps
`default_nettype none
module far_alarm_unit (
    // clock, resets, enable
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        powerOnReset_n,   // keeps reset cause alive
    input  wire logic        clkEn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // asynchronous pins
    input  wire logic        voltAlarm,
    input  wire logic        freqAlarm,
    input  wire logic        tempAlarm,
    input  wire logic        lightAlarm,
    input  wire logic        hvOk,
    input  wire logic        testStrap,
    input  wire logic        deliveredFuse,
    // same-clock detectors
    input  wire logic        fetchFault,
    input  wire logic        atuCacheFault,
    input  wire logic        romParityErr,
    input  wire logic        eeLightA,
    input  wire logic        eeLightB,
    input  wire logic        pcFault,
    input  wire logic        spFault,
    input  wire logic        pswHighFault,
    input  wire logic        cryptoFault,
    // stack pointer update from cpu
    input  wire logic [1:0]  privMode,
    input  wire logic        spWrEn,
    input  wire logic [15:0] spWrData,
    // eeprom read and write path
    input  wire logic        eeWriteActive,
    input  wire logic        eeRdValid,
    input  wire logic [31:0] eeRdData,
    input  wire logic [15:0] eeRdCheck,
    output logic      [31:0] eeCorrData,
    output logic             eeCorrValid,
    // responses
    output logic             chipResetReq,
    output logic             exceptionReq,
    output logic             sensorEnable
);
    // hamming(12,8) decode of one byte: {error, corrected byte}
    function automatic logic [8:0] fixByte(input logic [7:0] d, input logic [3:0] c);
        logic [3:0] s;
        logic [7:0] o;
        s = c ^ {d[7] ^ d[6] ^ d[5] ^ d[4], d[7] ^ d[3] ^ d[2] ^ d[1],
                 d[6] ^ d[5] ^ d[3] ^ d[2] ^ d[0], d[6] ^ d[4] ^ d[3] ^ d[1] ^ d[0]};
        o = d;
        case (s)
            4'h3:    o[0] = ~d[0];
            4'h5:    o[1] = ~d[1];
            4'h6:    o[2] = ~d[2];
            4'h7:    o[3] = ~d[3];
            4'h9:    o[4] = ~d[4];
            4'hA:    o[5] = ~d[5];
            4'hB:    o[6] = ~d[6];
            4'hC:    o[7] = ~d[7];
            default: o = d;      // check-bit flip or clean byte
        endcase
        return {s != 4'h0, o};
    endfunction

    // known register address
    function automatic logic known(input logic [11:0] a);
        return a == far_pkg::OFS_CTRL || a == far_pkg::OFS_RSTCAUSE ||
               a == far_pkg::OFS_EXCCAUSE || a == far_pkg::OFS_HVSTAT ||
               a == far_pkg::OFS_SPLIM_U || a == far_pkg::OFS_SPLIM_S ||
               a == far_pkg::OFS_SPLIM_X || a == far_pkg::OFS_STATUS;
    endfunction

    // pin synchronisers, first stage read only by second
    logic [6:0] pinMeta, pinSync;
    // state and registers
    far_pkg::far_state_t state, next_state;
    logic [2:0]  ctrl, next_ctrl;                 // invecc, eedet select
    logic [far_pkg::RC_W-1:0] rstCause, next_rstCause;
    logic [far_pkg::EC_W-1:0] excCause, next_excCause;
    logic [31:0] spLim [3], next_spLim [3];       // per mode {hi, lo}
    logic [15:0] sp [3], next_sp [3];             // per mode pointer
    logic        spOutPrev, next_spOutPrev;
    logic [1:0]  hvStat, next_hvStat;             // {ok, done}
    logic        hvBad, next_hvBad, wrPrev, next_wrPrev;
    logic        testMode, next_testMode;
    logic        strapDone, next_strapDone;
    logic [1:0]  settle, next_settle;
    logic [31:0] next_prdata, next_eeCorrData;
    logic        next_pready, next_pslverr, next_eeCorrValid;
    logic        next_chipResetReq, next_exceptionReq, next_sensorEnable;
    // combinational helpers
    logic [far_pkg::RC_W-1:0] rstVec;
    logic [far_pkg::EC_W-1:0] excVec;
    logic        resetClass, excClass, eccErr, spOut, apbWr;
    logic [1:0]  modeIdx;
    logic [8:0]  fix [4];

    // synchronise pins; frozen with the rest while clkEn is low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinMeta <= 7'h00;
            pinSync <= 7'h00;
        end else if (clkEn) begin
            pinMeta <= {voltAlarm, freqAlarm, tempAlarm, lightAlarm,
                        hvOk, testStrap, deliveredFuse};
            pinSync <= pinMeta;
        end
    end

    // alarm classification; fixed wiring, ctrl gates only the eeprom light and ecc exceptions
    always_comb begin
        rstVec = '0;
        rstVec[far_pkg::RC_VOLT]   = pinSync[6];
        rstVec[far_pkg::RC_FREQ]   = pinSync[5];
        rstVec[far_pkg::RC_TEMP]   = pinSync[4];
        rstVec[far_pkg::RC_LIGHT]  = pinSync[3];
        rstVec[far_pkg::RC_FETCH]  = fetchFault;
        rstVec[far_pkg::RC_ATU]    = atuCacheFault;
        rstVec[far_pkg::RC_ROMPAR] = romParityErr;
        for (int i = 0; i < 4; i++) begin
            fix[i] = fixByte(eeRdData[8*i +: 8], eeRdCheck[4*i +: 4]);
        end
        eccErr = eeRdValid && ctrl[far_pkg::CTRL_INVECC] &&
                 (fix[0][8] || fix[1][8] || fix[2][8] || fix[3][8]);
        modeIdx = (privMode == far_pkg::FAR_SUPER) ? 2'd2 :
                  (privMode == far_pkg::FAR_SYSTEM) ? 2'd1 : 2'd0;
        spOut = sp[modeIdx] < spLim[modeIdx][15:0] ||
                sp[modeIdx] > spLim[modeIdx][31:16];
        excVec = '0;
        // only the selected light function reports
        excVec[far_pkg::EC_EELIGHT] =
            (ctrl[2:1] == far_pkg::FAR_EEDET_A && eeLightA) ||
            (ctrl[2:1] == far_pkg::FAR_EEDET_B && eeLightB);
        excVec[far_pkg::EC_PC]     = pcFault;
        excVec[far_pkg::EC_SP]     = spFault;
        excVec[far_pkg::EC_PROGRAM_STATUS_WORD_HIGH]   = pswHighFault;
        excVec[far_pkg::EC_CRYPTO] = cryptoFault;
        excVec[far_pkg::EC_ECC]    = eccErr;
        excVec[far_pkg::EC_STACK]  = spOut && !spOutPrev;       // entry edge only
        resetClass = |rstVec;
        excClass   = |excVec;
        apbWr      = psel && penable && pready && pwrite && !pslverr;
    end

    // next values of all reset_n state except the pin synchronisers
    always_comb begin
        next_state = state;
        next_chipResetReq = chipResetReq;
        next_exceptionReq = 1'b0;
        next_excCause = excCause;
        next_ctrl = ctrl;
        next_spLim = spLim;
        next_sp = sp;
        // abort: hold the reset request until reset_n arrives
        case (state)
            far_pkg::FAR_RUN: begin
                if (resetClass) begin
                    next_state = far_pkg::FAR_ABORT;
                    next_chipResetReq = 1'b1;
                end else if (excClass) begin
                    next_exceptionReq = 1'b1;
                end
            end
            far_pkg::FAR_ABORT: next_chipResetReq = 1'b1;
            default: next_state = far_pkg::FAR_RUN;
        endcase
        // exception cause, write one to clear, set wins
        if (apbWr && paddr == far_pkg::OFS_EXCCAUSE) begin
            next_excCause = excCause & ~pwdata[far_pkg::EC_W-1:0];
        end
        if (next_exceptionReq) begin
            next_excCause = next_excCause | excVec;
        end
        if (apbWr && paddr == far_pkg::OFS_CTRL) begin
            next_ctrl = pwdata[2:0];
        end
        if (apbWr && paddr == far_pkg::OFS_SPLIM_U) next_spLim[0] = pwdata;
        if (apbWr && paddr == far_pkg::OFS_SPLIM_S) next_spLim[1] = pwdata;
        if (apbWr && paddr == far_pkg::OFS_SPLIM_X) next_spLim[2] = pwdata;
        if (spWrEn) next_sp[modeIdx] = spWrData;
        next_spOutPrev = spOut;
        // high voltage check over each write sequence, no event raised
        next_wrPrev = eeWriteActive;
        next_hvBad = eeWriteActive ? (hvBad || !pinSync[2]) : 1'b0;
        next_hvStat = hvStat;
        if (wrPrev && !eeWriteActive) begin
            next_hvStat = {!hvBad, 1'b1};
        end
        // strap catch once after release; delivered part never tests
        next_settle = (settle == far_pkg::STRAP_SETTLE) ? settle : settle + 2'd1;
        next_strapDone = strapDone || settle == far_pkg::STRAP_SETTLE;
        next_testMode = testMode;
        if (!strapDone && settle == far_pkg::STRAP_SETTLE) begin
            next_testMode = pinSync[1] && !pinSync[0];
        end
        next_sensorEnable = !next_testMode;
        next_eeCorrValid = eeRdValid;
        next_eeCorrData = eeRdValid ? {fix[3][7:0], fix[2][7:0], fix[1][7:0],
                                       fix[0][7:0]} : eeCorrData;
        // apb: answer in the access cycle after setup
        next_pready = psel && !penable;
        next_pslverr = psel && !penable && !known(paddr);
        next_prdata = 32'h0000_0000;
        if (psel && !penable) begin
            case (paddr)
                far_pkg::OFS_CTRL:     next_prdata = {29'h0, ctrl};
                far_pkg::OFS_RSTCAUSE: next_prdata = {25'h0, rstCause};
                far_pkg::OFS_EXCCAUSE: next_prdata = {25'h0, excCause};
                far_pkg::OFS_HVSTAT:   next_prdata = {30'h0, hvStat};
                far_pkg::OFS_SPLIM_U:  next_prdata = spLim[0];
                far_pkg::OFS_SPLIM_S:  next_prdata = spLim[1];
                far_pkg::OFS_SPLIM_X:  next_prdata = spLim[2];
                far_pkg::OFS_STATUS:   next_prdata = {28'h0, privMode,
                                                      sensorEnable, testMode};
                default:               next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // register everything cleared by chip reset except the pin synchronisers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= far_pkg::FAR_RUN;
            chipResetReq <= 1'b0;
            exceptionReq <= 1'b0;
            excCause <= '0;
            ctrl <= far_pkg::CTRL_RST;
            for (int i = 0; i < 3; i++) begin
                spLim[i] <= far_pkg::SPLIM_RST;
                sp[i] <= 16'h0000;
            end
            spOutPrev <= 1'b0;
            hvStat <= 2'h0;
            hvBad <= 1'b0;
            wrPrev <= 1'b0;
            settle <= 2'h0;
            strapDone <= 1'b0;
            testMode <= 1'b0;
            sensorEnable <= 1'b1;
            eeCorrValid <= 1'b0;
            eeCorrData <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (clkEn) begin
            state <= next_state;
            chipResetReq <= next_chipResetReq;
            exceptionReq <= next_exceptionReq;
            excCause <= next_excCause;
            ctrl <= next_ctrl;
            spLim <= next_spLim;
            sp <= next_sp;
            spOutPrev <= next_spOutPrev;
            hvStat <= next_hvStat;
            hvBad <= next_hvBad;
            wrPrev <= next_wrPrev;
            settle <= next_settle;
            strapDone <= next_strapDone;
            testMode <= next_testMode;
            sensorEnable <= next_sensorEnable;
            eeCorrValid <= next_eeCorrValid;
            eeCorrData <= next_eeCorrData;
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    // reset cause outlives the chip reset it explains; set wins over clear
    always_comb begin
        next_rstCause = rstCause;
        if (apbWr && paddr == far_pkg::OFS_RSTCAUSE) begin
            next_rstCause = rstCause & ~pwdata[far_pkg::RC_W-1:0];
        end
        if (state == far_pkg::FAR_RUN) begin
            next_rstCause = next_rstCause | rstVec;
        end
    end

    always_ff @(posedge clk or negedge powerOnReset_n) begin
        if (!powerOnReset_n) begin
            rstCause <= '0;
        end else if (clkEn) begin
            rstCause <= next_rstCause;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence runAlarm;
        clkEn && state == far_pkg::FAR_RUN && resetClass;
    endsequence
    sequence wrEnd;
        clkEn && wrPrev && !eeWriteActive;
    endsequence
    AST_RESET_SRC: assert property (runAlarm |=> chipResetReq && !exceptionReq)
        else $error("reset alarm did not force chip reset");
    AST_EXC_SRC: assert property (clkEn && state == far_pkg::FAR_RUN && !resetClass
        && excClass |=> exceptionReq && !chipResetReq)
        else $error("exception alarm not raised as exception");
    AST_ABORT_HOLD: assert property ($rose(chipResetReq) |-> chipResetReq[*4])
        else $error("reset request dropped before reset");
    AST_CAUSE_KEPT: assert property (runAlarm |=> (rstCause & $past(rstVec))
        == $past(rstVec))
        else $error("reset cause not recorded");
    AST_EXC_CAUSE: assert property (exceptionReq |-> excCause != '0)
        else $error("exception without cause");
    AST_ECC_EXC: assert property (clkEn && eccErr && !resetClass &&
        state == far_pkg::FAR_RUN |=> exceptionReq && excCause[far_pkg::EC_ECC])
        else $error("correction error raised no exception");
    AST_SENSOR_ON: assert property (strapDone && !testMode |-> sensorEnable)
        else $error("sensors off outside test mode");
    AST_STACK: assert property (clkEn && spOut && !spOutPrev && !resetClass &&
        state == far_pkg::FAR_RUN |=> exceptionReq && excCause[far_pkg::EC_STACK])
        else $error("stack limit exception missing");
    AST_HV_POST: assert property (wrEnd |=> hvStat[far_pkg::HV_DONE])
        else $error("high voltage result not posted");
    AST_ECC_FIX: assert property (clkEn && eeRdValid |=> eeCorrValid)
        else $error("corrected read data missing");
    AST_ROM_RST: assert property (clkEn && romParityErr && state == far_pkg::FAR_RUN
        |=> chipResetReq && rstCause[far_pkg::RC_ROMPAR])
        else $error("rom parity did not reset");
    AST_DELIVERED: assert property (strapDone && $past(pinSync[0], 1)
        && !$past(strapDone) |-> !testMode)
        else $error("test mode after delivery");
    AST_RESET_WINS: assert property (runAlarm and excClass |=> !exceptionReq)
        else $error("exception taken with reset");
endmodule // far_alarm_unit
`default_nettype wire

// [far_pkg.sv]
// far_pkg: shared constants for the fault alarm response unit
// assumes a 32-bit apb slave with word-aligned registers
package far_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_CTRL     = 12'h000;
    localparam logic [11:0] OFS_RSTCAUSE = 12'h004;
    localparam logic [11:0] OFS_EXCCAUSE = 12'h008;
    localparam logic [11:0] OFS_HVSTAT   = 12'h00C;
    localparam logic [11:0] OFS_SPLIM_U  = 12'h010;
    localparam logic [11:0] OFS_SPLIM_S  = 12'h014;
    localparam logic [11:0] OFS_SPLIM_X  = 12'h018;
    localparam logic [11:0] OFS_STATUS   = 12'h01C;
    // field positions
    localparam int CTRL_INVECC = 0;    // inverse error correction enable
    localparam int CTRL_EEDET  = 1;    // two-bit light detect select
    localparam int HV_DONE     = 0;
    localparam int HV_OK       = 1;
    localparam int ST_TEST     = 0;
    localparam int ST_SENSOR   = 1;
    localparam int ST_MODE     = 2;
    localparam int SP_W        = 16;
    // reset cause bits
    localparam int RC_VOLT = 0, RC_FREQ = 1, RC_TEMP = 2, RC_LIGHT = 3;
    localparam int RC_FETCH = 4, RC_ATU = 5, RC_ROMPAR = 6, RC_W = 7;
    // exception cause bits
    localparam int EC_EELIGHT = 0, EC_PC = 1, EC_SP = 2, EC_PROGRAM_STATUS_WORD_HIGH = 3;
    localparam int EC_CRYPTO = 4, EC_ECC = 5, EC_STACK = 6, EC_W = 7;
    // reset values
    localparam logic [2:0]  CTRL_RST  = 3'h0;
    localparam logic [31:0] SPLIM_RST = 32'hFFFF_0000;  // hi:lo, full range
    localparam logic [1:0]  STRAP_SETTLE = 2'h3;        // cycles before strap catch
    typedef enum logic [1:0] {FAR_EEDET_OFF = 2'b00, FAR_EEDET_A = 2'b01,
                              FAR_EEDET_B = 2'b10} far_eedet_t;
    typedef enum logic [1:0] {FAR_USER = 2'b00, FAR_SYSTEM = 2'b01,
                              FAR_SUPER = 2'b10} far_mode_t;
    typedef enum logic {FAR_RUN = 1'b0, FAR_ABORT = 1'b1} far_state_t;
endpackage

// [test_fault_alarm_response.sv]
// test_fault_alarm_response: self-checking bench for the fault alarm response unit
// assumes far_pkg and far_alarm_unit are compiled first; the bench drives every port
`timescale 1ns/1ps
`default_nettype none
module test_fault_alarm_response;
    // clock, resets, apb
    logic        clk, reset_n, powerOnReset_n, clkEn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, eeRdData, eeCorrData, rd;
    // pins and detectors
    logic        voltAlarm, freqAlarm, tempAlarm, lightAlarm, hvOk, testStrap, deliveredFuse;
    logic        fetchFault, atuCacheFault, romParityErr, eeLightA, eeLightB;
    logic        pcFault, spFault, pswHighFault, cryptoFault;
    // cpu and eeprom side, responses
    logic [1:0]  privMode;
    logic [15:0] spWrData, eeRdCheck;
    logic        spWrEn, eeWriteActive, eeRdValid, eeCorrValid;
    logic        chipResetReq, exceptionReq, sensorEnable, err, seen;
    int          miscompares = 0;
    int          n_checks    = 0;

    far_alarm_unit dut_u (.clk, .reset_n, .powerOnReset_n, .clkEn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .voltAlarm, .freqAlarm, .tempAlarm,
        .lightAlarm, .hvOk, .testStrap, .deliveredFuse, .fetchFault, .atuCacheFault,
        .romParityErr, .eeLightA, .eeLightB, .pcFault, .spFault, .pswHighFault, .cryptoFault,
        .privMode, .spWrEn, .spWrData, .eeWriteActive, .eeRdValid, .eeRdData, .eeRdCheck,
        .eeCorrData, .eeCorrValid, .chipResetReq, .exceptionReq, .sensorEnable);

    // free-running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // verdict, shared by main sequence and watchdog
    task automatic stop_test();
        if (miscompares == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // word and flag comparisons
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp, input string m);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %b want %b", $time, m, got, exp);
        end
    endtask

    // one apb transfer; answer taken at the rising edge where pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no wait-state count assumed; only the watchdog ends a hung wait
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // bounded wait for a response; pulses are caught because every cycle is polled
    task automatic wait_resp(input logic rstSel);
        seen = 1'b0;
        for (int i = 0; i < 8 && !seen; i++) begin
            #1;
            seen = rstSel ? chipResetReq : exceptionReq;
            if (!seen) @(posedge clk);
        end
    endtask

    // short chip reset; reset cause must survive it
    task automatic chip_reset();
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        check_bit(chipResetReq, 1'b0, "abort cleared");
        check_bit(sensorEnable, 1'b1, "sensors on");
    endtask

    task automatic set_src(input int k, input logic v);
        case (k)
            0: voltAlarm <= v;
            1: freqAlarm <= v;
            2: tempAlarm <= v;
            3: lightAlarm <= v;
            4: fetchFault <= v;
            5: atuCacheFault <= v;
            6: romParityErr <= v;
            7: eeLightA <= v;
            8: eeLightB <= v;
            9: pcFault <= v;
            10: spFault <= v;
            11: pswHighFault <= v;
            default: cryptoFault <= v;
        endcase
    endtask

    // reset values, unmapped place, read-only status
    task automatic t_reset_values();
        apb(1'b0, far_pkg::OFS_CTRL, 32'h0);
        check_word(rd, 32'h0, "ctrl reset");
        for (int m = 0; m < 3; m++) begin
            apb(1'b0, far_pkg::OFS_SPLIM_U + 12'(4 * m), 32'h0);
            check_word(rd, far_pkg::SPLIM_RST, "limit reset");
        end
        apb(1'b0, 12'h020, 32'h0);
        check_bit(err, 1'b1, "unmapped error");
        check_word(rd, 32'h0, "unmapped data");
        apb(1'b1, far_pkg::OFS_STATUS, 32'h0);
        apb(1'b0, far_pkg::OFS_STATUS, 32'h0);
        check_word(rd, 32'h2, "sensors stay on, no test");
    endtask

    // every reset-class source forces a reset and leaves its cause readable
    task automatic t_reset_class();
        for (int k = 0; k < 7; k++) begin
            @(posedge clk);
            set_src(k, 1'b1);
            repeat (3) @(posedge clk);
            set_src(k, 1'b0);
            wait_resp(1'b1);
            check_bit(seen, 1'b1, "reset forced");
            check_bit(exceptionReq, 1'b0, "no exception");
            repeat (3) @(posedge clk);
            #1;
            check_bit(chipResetReq, 1'b1, "abort held");
            chip_reset();
            apb(1'b0, far_pkg::OFS_RSTCAUSE, 32'h0);
            check_word(rd, 32'h1 << k, "reset cause");
            apb(1'b1, far_pkg::OFS_RSTCAUSE, 32'h7F);
        end
    endtask

    // every exception-class detector input pulses an exception, cause readable
    task automatic t_exception_class();
        // light function not selected by software: its alarm stays silent
        apb(1'b1, far_pkg::OFS_CTRL, 32'h4);
        @(posedge clk);
        eeLightA <= 1'b1;
        @(posedge clk);
        eeLightA <= 1'b0;
        wait_resp(1'b0);
        check_bit(seen, 1'b0, "unselected light ignored");
        for (int k = 7; k < 13; k++) begin
            apb(1'b1, far_pkg::OFS_CTRL, (k == 8) ? 32'h4 : 32'h2);
            @(posedge clk);
            set_src(k, 1'b1);
            @(posedge clk);
            set_src(k, 1'b0);
            wait_resp(1'b0);
            check_bit(seen, 1'b1, "exception raised");
            check_bit(chipResetReq, 1'b0, "no reset");
            apb(1'b0, far_pkg::OFS_EXCCAUSE, 32'h0);
            check_word(rd, 32'h1 << ((k < 9) ? 0 : k - 8), "exception cause");
            apb(1'b1, far_pkg::OFS_EXCCAUSE, 32'h7F);
        end
    endtask

    // same-cycle reset and exception: the exception is dropped
    task automatic t_priority();
        @(posedge clk);
        fetchFault <= 1'b1;
        pcFault    <= 1'b1;
        @(posedge clk);
        fetchFault <= 1'b0;
        pcFault    <= 1'b0;
        #1;
        check_bit(chipResetReq, 1'b1, "reset wins");
        check_bit(exceptionReq, 1'b0, "exception dropped");
        chip_reset();
        apb(1'b1, far_pkg::OFS_RSTCAUSE, 32'h7F);
    endtask

    // one flipped bit per byte of an all-zero word; exception only when enabled
    task automatic t_ecc();
        for (int e = 1; e >= 0; e--) begin
            apb(1'b1, far_pkg::OFS_CTRL, 32'(e));
            @(posedge clk);
            eeRdValid <= 1'b1;
            eeRdData  <= 32'h0180_4001;
            @(posedge clk);
            eeRdValid <= 1'b0;
            #1;
            check_bit(eeCorrValid, 1'b1, "corrected valid");
            check_word(eeCorrData, 32'h0, "corrected data");
            check_bit(exceptionReq, e[0], "ecc exception");
        end
        apb(1'b1, far_pkg::OFS_EXCCAUSE, 32'h7F);
    endtask

    // write voltage flag posted with no event, good and bad
    task automatic t_hv();
        for (int v = 0; v < 2; v++) begin
            hvOk <= v[0];
            repeat (3) @(posedge clk);
            eeWriteActive <= 1'b1;
            repeat (4) @(posedge clk);
            eeWriteActive <= 1'b0;
            wait_resp(1'b0);
            check_bit(seen | chipResetReq, 1'b0, "no event");
            apb(1'b0, far_pkg::OFS_HVSTAT, 32'h0);
            check_word(rd, {30'h0, v[0], 1'b1}, "voltage status");
        end
    endtask

    // each mode's own pointer leaves its own range
    task automatic t_stack();
        for (int m = 0; m < 3; m++) begin
            @(posedge clk);
            privMode <= 2'(m);
            spWrEn   <= 1'b1;
            spWrData <= 16'h0020;
            @(posedge clk);
            spWrEn <= 1'b0;
            apb(1'b1, far_pkg::OFS_SPLIM_U + 12'(4 * m), 32'h0100_0010);
            apb(1'b0, far_pkg::OFS_STATUS, 32'h0);
            check_word(rd, {28'h0, 2'(m), 2'b10}, "status mode");
            @(posedge clk);
            spWrEn   <= 1'b1;
            spWrData <= 16'h0200;
            @(posedge clk);
            spWrEn <= 1'b0;
            wait_resp(1'b0);
            check_bit(seen, 1'b1, "stack exception");
            apb(1'b0, far_pkg::OFS_EXCCAUSE, 32'h0);
            check_word(rd, 32'h40, "stack cause");
            apb(1'b1, far_pkg::OFS_EXCCAUSE, 32'h7F);
        end
    endtask

    // main sequence
    initial begin
        {reset_n, powerOnReset_n, psel, penable, pwrite, hvOk, testStrap} = '0;
        {voltAlarm, freqAlarm, tempAlarm, lightAlarm, fetchFault, atuCacheFault} = '0;
        {romParityErr, eeLightA, eeLightB, pcFault, spFault, pswHighFault, cryptoFault} = '0;
        {spWrEn, eeWriteActive, eeRdValid, privMode, spWrData, eeRdCheck} = '0;
        {paddr, pwdata, eeRdData} = '0;
        clkEn         = 1'b1;
        deliveredFuse = 1'b1;
        testStrap     = 1'b1;   // strap set but fuse blown: test must stay off
        repeat (3) @(posedge clk);
        reset_n        <= 1'b1;
        powerOnReset_n <= 1'b1;
        repeat (5) @(posedge clk);
        t_reset_values();
        t_reset_class();
        t_exception_class();
        t_priority();
        t_ecc();
        t_hv();
        t_stack();
        stop_test();
    end

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        stop_test();
    end
endmodule // test_fault_alarm_response
`default_nettype wire
